//--- hw/ssc_pkg.sv
// constants and types shared by the serial port design
package ssc_pkg;
   // register byte offsets on the avalon slave
   localparam logic [4:0] OFS_DATA_BUF   = 5'h00;
   localparam logic [4:0] OFS_CONTROL    = 5'h04;
   localparam logic [4:0] OFS_STATUS     = 5'h08;
   localparam logic [4:0] OFS_IRQ_STATUS = 5'h0c;
   localparam logic [4:0] OFS_IRQ_MASK   = 5'h10;
   // serial_control_one fields
   localparam int CTL_WRITE_COLLISION_FLAG = 7;
   localparam int CTL_OVF  = 6;
   localparam int CTL_EN   = 5;
   localparam int CTL_CKP  = 4;
   localparam int CTL_MODE = 0;
   // serial_status fields
   localparam int STA_SMP = 7;
   localparam int STA_CKE = 6;
   localparam int STA_BF  = 0;
   // interrupt status / mask fields
   localparam int IRQ_DONE = 0;
   localparam int IRQ_WRITE_COLLISION_FLAG = 1;
   localparam int IRQ_OVF  = 2;
   localparam int IRQ_W    = 3;
   // port_mode_field codes
   localparam logic [3:0] MODE_MST_DIV4  = 4'h0;
   localparam logic [3:0] MODE_MST_DIV16 = 4'h1;
   localparam logic [3:0] MODE_MST_DIV64 = 4'h2;
   localparam logic [3:0] MODE_MST_TMR   = 4'h3;
   localparam logic [3:0] MODE_SLV_SS    = 4'h4;
   localparam logic [3:0] MODE_SLV_NOSS  = 4'h5;
   // half bit-period in ticks: peripheral ticks, timer ticks for HALF_TMR
   localparam logic [4:0] HALF_DIV4  = 5'h02;
   localparam logic [4:0] HALF_DIV16 = 5'h08;
   localparam logic [4:0] HALF_DIV64 = 5'h1f + 5'h01;
   localparam logic [4:0] HALF_TMR   = 5'h01;
   // byte framing
   localparam logic [2:0] LAST_BIT  = 3'h7;
   localparam logic [3:0] LAST_EDGE = 4'hf;
   localparam int         MSB       = 7;
   typedef enum logic {MST_IDLE, MST_SHIFT} ssc_mst_t;
endpackage

//--- hw/ssc_spi_port.sv
// spi port: slave select, power modes, registers on avalon-mm
//
// Our own choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module ssc_spi_port (
   // clock, reset, clock enable
   input  wire logic        I_MCLK,
   input  wire logic        I_SYS_RST,
   input  wire logic        I_CE,
   // avalon-mm slave
   input  wire logic [4:0]  I_AVS_ADDRESS,
   input  wire logic        I_AVS_READ,
   input  wire logic        I_AVS_WRITE,
   input  wire logic [31:0] I_AVS_WRITEDATA,
   input  wire logic [3:0]  I_AVS_BYTEENABLE,
   output logic      [31:0] O_AVS_READDATA,
   output logic             O_AVS_WAITREQUEST,
   // power management and clock sources
   input  wire logic        I_SLEEP,
   input  wire logic        I_IDLE,
   input  wire logic        I_PERIPH_TICK,
   input  wire logic        I_TMR_TICK,
   input  wire logic        I_SDO_DIR_IN,
   // serial pins
   input  wire logic        I_SCK,
   output logic             O_SCK,
   output logic             O_SCK_OE,
   input  wire logic        I_SDI,
   output logic             O_SDO,
   output logic             O_SDO_OE,
   input  wire logic        I_SS_N,
   // interrupt and wake
   output logic             O_IRQ,
   output logic             O_WAKE
);
   logic [2:0]          pin_s;
   logic                sck_s;
   logic                sdi_s;
   logic                ss_n_s;
   logic                sck_prev;
   logic [7:0]          control;
   logic                sample_phase_select;
   logic                cke;
   logic [7:0]          rx_buf;
   logic                bf;
   logic [7:0]          sr;
   logic                sdo_q;
   logic [2:0]          bit_cnt;
   ssc_pkg::ssc_mst_t   mst_state;
   logic [3:0]          edge_idx;
   logic [4:0]          div_cnt;
   logic                sck_q;
   logic [ssc_pkg::IRQ_W-1:0] irq_stat;
   logic [ssc_pkg::IRQ_W-1:0] irq_mask;
   logic                ack;
   logic                req;
   logic                acc;
   logic                wr_ok;
   logic                rd_ok;
   logic [3:0]          mode;
   logic                en;
   logic                clock_idle_level;
   logic                is_master;
   logic                is_slave;
   logic                mod_rst;
   logic                active;
   logic                load;
   logic                write_collision_flag_ev;
   logic                tick;
   logic                m_edge;
   logic                ev_a;
   logic                ev_b;
   logic                samp;
   logic                outv;
   logic                done_ev;
   logic                ovf_ev;
   logic [7:0]          sr_in;

   // sample phase: slaves ignore the smp bit and sample on the edge that cke picks
   function automatic logic sample_at_a(input logic c, input logic s, input logic m);
      sample_at_a = c & ~(s & m);
   endfunction

   function automatic logic [4:0] half_period(input logic [3:0] md);
      logic [4:0] h;
      h = ssc_pkg::HALF_TMR;
      unique case (md)
         ssc_pkg::MODE_MST_DIV4:  h = ssc_pkg::HALF_DIV4;
         ssc_pkg::MODE_MST_DIV16: h = ssc_pkg::HALF_DIV16;
         ssc_pkg::MODE_MST_DIV64: h = ssc_pkg::HALF_DIV64;
         default:                 h = ssc_pkg::HALF_TMR;
      endcase
      half_period = h;
   endfunction

   ssc_sync2 #(.W(3)) u_sync (
      .i_clk (I_MCLK),
      .i_rst (I_SYS_RST),
      .i_ce  (I_CE),
      .i_d   ({I_SCK, I_SDI, I_SS_N}),
      .o_q   (pin_s)
   );

   assign sck_s  = pin_s[2];
   assign sdi_s  = pin_s[1];
   assign ss_n_s = pin_s[0];

   assign mode      = control[ssc_pkg::CTL_MODE +: 4];
   assign en        = control[ssc_pkg::CTL_EN];
   assign clock_idle_level       = control[ssc_pkg::CTL_CKP];
   assign is_master = en & (mode <= ssc_pkg::MODE_MST_TMR);
   assign is_slave  = en & ((mode == ssc_pkg::MODE_SLV_SS) | (mode == ssc_pkg::MODE_SLV_NOSS));
   // select-high or disable resets; no serial edge needed
   assign mod_rst   = ~(is_master | is_slave) | ((mode == ssc_pkg::MODE_SLV_SS) & ss_n_s);
   assign active    = is_master ? (mst_state == ssc_pkg::MST_SHIFT) : (bit_cnt != '0);

   // one wait state: request taken on the edge where waitrequest is low
   assign req   = I_AVS_READ | I_AVS_WRITE;
   assign acc   = req & ack & I_CE;
   assign wr_ok = acc & I_AVS_WRITE & I_AVS_BYTEENABLE[0];
   assign rd_ok = acc & I_AVS_READ;
   // a low clock enable must not let the master finish an access that never lands
   assign O_AVS_WAITREQUEST = req & ~(ack & I_CE);

   assign load    = wr_ok & (I_AVS_ADDRESS == ssc_pkg::OFS_DATA_BUF) & ~active
                    & (is_master | is_slave);
   assign write_collision_flag_ev = wr_ok & (I_AVS_ADDRESS == ssc_pkg::OFS_DATA_BUF) & active;

   // sleep stops master clock; idle rate follows the peripheral tick, or the timer tick in timer mode
   assign tick   = (mode == ssc_pkg::MODE_MST_TMR) ? I_TMR_TICK : I_PERIPH_TICK;
   assign m_edge = (mst_state == ssc_pkg::MST_SHIFT) & ~I_SLEEP & tick
                   & (div_cnt == half_period(mode) - 5'h01);

   always_comb begin
      ev_a = 1'b0;
      ev_b = 1'b0;
      if (is_master) begin
         ev_a = m_edge & ~edge_idx[0];
         ev_b = m_edge & edge_idx[0];
      end else if (is_slave & ~mod_rst) begin
         // slave edges come only from the external clock
         ev_a = (sck_s != sck_prev) & (sck_s != clock_idle_level);
         ev_b = (sck_s != sck_prev) & (sck_s == clock_idle_level);
      end
   end

   // edge select and sample phase pick the events
   assign samp    = sample_at_a(cke, sample_phase_select, is_master) ? ev_a : ev_b;
   assign outv    = cke ? ev_b : ev_a;
   assign done_ev = samp & (bit_cnt == ssc_pkg::LAST_BIT);
   assign ovf_ev  = done_ev & bf;
   assign sr_in   = {sr[ssc_pkg::MSB-1:0], sdi_s};

   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         sck_prev <= 1'b0;
      end else if (I_CE) begin
         sck_prev <= sck_s;
      end
   end

   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         sr      <= 8'h00;
         sdo_q   <= 1'b0;
         bit_cnt <= 3'h0;
      end else if (I_CE) begin
         // a deselected slave is loaded ahead of its next frame
         if (load) begin
            sr <= I_AVS_WRITEDATA[7:0];
            // with cke set, msb presented before the first edge
            if (cke) begin
               sdo_q <= I_AVS_WRITEDATA[ssc_pkg::MSB];
            end
         end
         if (mod_rst) begin
            bit_cnt <= 3'h0;
         end else begin
            if (samp) begin
               sr      <= sr_in;
               bit_cnt <= bit_cnt + 3'h1;
            end
            if (outv) begin
               sdo_q <= samp ? sr[ssc_pkg::MSB-1] : sr[ssc_pkg::MSB];
            end
         end
      end
   end

   // master clock generator
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         mst_state <= ssc_pkg::MST_IDLE;
         edge_idx  <= 4'h0;
         div_cnt   <= 5'h00;
         sck_q     <= 1'b0;
      end else if (I_CE) begin
         if (mod_rst | ~is_master) begin
            mst_state <= ssc_pkg::MST_IDLE;
            edge_idx  <= 4'h0;
            div_cnt   <= 5'h00;
            sck_q     <= clock_idle_level;
         end else begin
            unique case (mst_state)
               ssc_pkg::MST_IDLE: begin
                  sck_q    <= clock_idle_level;
                  edge_idx <= 4'h0;
                  div_cnt  <= 5'h00;
                  if (load) begin
                     mst_state <= ssc_pkg::MST_SHIFT;
                  end
               end
               ssc_pkg::MST_SHIFT: begin
                  // counting halts while asleep, state kept
                  if (m_edge) begin
                     div_cnt  <= 5'h00;
                     sck_q    <= ~sck_q;
                     edge_idx <= edge_idx + 4'h1;
                     if (edge_idx == ssc_pkg::LAST_EDGE) begin
                        mst_state <= ssc_pkg::MST_IDLE;
                     end
                  end else if (tick & ~I_SLEEP) begin
                     div_cnt <= div_cnt + 5'h01;
                  end
               end
            endcase
         end
      end
   end

   // buffer, buffer-full and sticky error flags; set wins over clear
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         rx_buf <= 8'h00;
         bf     <= 1'b0;
      end else if (I_CE) begin
         if (done_ev & ~bf) begin
            rx_buf <= sr_in;
         end
         if (done_ev) begin
            bf <= 1'b1;
         end else if (rd_ok & (I_AVS_ADDRESS == ssc_pkg::OFS_DATA_BUF)) begin
            bf <= 1'b0;
         end
      end
   end

   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         control <= 8'h00;
         sample_phase_select     <= 1'b0;
         cke     <= 1'b0;
      end else if (I_CE) begin
         if (wr_ok & (I_AVS_ADDRESS == ssc_pkg::OFS_CONTROL)) begin
            control <= I_AVS_WRITEDATA[7:0];
         end
         if (wr_ok & (I_AVS_ADDRESS == ssc_pkg::OFS_STATUS)) begin
            sample_phase_select <= I_AVS_WRITEDATA[ssc_pkg::STA_SMP];
            cke <= I_AVS_WRITEDATA[ssc_pkg::STA_CKE];
         end
         if (write_collision_flag_ev) begin
            control[ssc_pkg::CTL_WRITE_COLLISION_FLAG] <= 1'b1;
         end
         if (ovf_ev) begin
            control[ssc_pkg::CTL_OVF] <= 1'b1;
         end
      end
   end

   // interrupt status cleared by reading it, masked onto one level
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         irq_stat <= '0;
         irq_mask <= '0;
      end else if (I_CE) begin
         if (rd_ok & (I_AVS_ADDRESS == ssc_pkg::OFS_IRQ_STATUS)) begin
            irq_stat <= '0;
         end
         // transfer complete raises the done flag
         if (done_ev) begin
            irq_stat[ssc_pkg::IRQ_DONE] <= 1'b1;
         end
         if (write_collision_flag_ev) begin
            irq_stat[ssc_pkg::IRQ_WRITE_COLLISION_FLAG] <= 1'b1;
         end
         if (ovf_ev) begin
            irq_stat[ssc_pkg::IRQ_OVF] <= 1'b1;
         end
         if (wr_ok & (I_AVS_ADDRESS == ssc_pkg::OFS_IRQ_MASK)) begin
            irq_mask <= I_AVS_WRITEDATA[ssc_pkg::IRQ_W-1:0];
         end
      end
   end

   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         O_IRQ  <= 1'b0;
         O_WAKE <= 1'b0;
      end else if (I_CE) begin
         O_IRQ  <= |(irq_stat & irq_mask);
         // only an enabled interrupt wakes the controller
         O_WAKE <= |(irq_stat & irq_mask) & (I_SLEEP | I_IDLE);
      end
   end

   // bus answer and read data
   always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
      if (I_SYS_RST) begin
         ack            <= 1'b0;
         O_AVS_READDATA <= 32'h0000_0000;
      end else if (I_CE) begin
         ack <= req & ~ack;
         if (req & ~ack) begin
            unique case (I_AVS_ADDRESS)
               ssc_pkg::OFS_DATA_BUF:   O_AVS_READDATA <= {24'h000000, rx_buf};
               ssc_pkg::OFS_CONTROL:    O_AVS_READDATA <= {24'h000000, control};
               ssc_pkg::OFS_STATUS:     O_AVS_READDATA <= {24'h000000, sample_phase_select, cke, 5'h00, bf};
               ssc_pkg::OFS_IRQ_STATUS: O_AVS_READDATA <= {29'h00000000, irq_stat};
               ssc_pkg::OFS_IRQ_MASK:   O_AVS_READDATA <= {29'h00000000, irq_mask};
               default:                 O_AVS_READDATA <= 32'h0000_0000;
            endcase
         end
      end
   end

   // pins
   assign O_SCK    = is_master ? sck_q : clock_idle_level;
   assign O_SCK_OE = is_master;
   assign O_SDO    = sdo_q;
   // drive only while selected and the pin is an output
   assign O_SDO_OE = (is_master | is_slave) & ~mod_rst & ~I_SDO_DIR_IN;
endmodule
`default_nettype wire

//--- hw/ssc_sync2.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module ssc_sync2 #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_rst,
   input  wire logic         i_ce,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta <= '0;
         o_q  <= '0;
      end else if (i_ce) begin
         meta <= i_d;
         o_q  <= meta;
      end
   end
endmodule
`default_nettype wire

//--- test/ssc_spi_far_master.sv
// behavioural spi master on the far side of the slave port
`timescale 1ns/10ps
`default_nettype none
module ssc_spi_far_master (
   // data from the port
   input  wire logic i_sdo,
   input  wire logic i_sdo_oe,
   // link lines
   output logic      o_sck,
   output logic      o_sdi,
   output logic      o_ss_n
);
   localparam int HALF_NS = 24;
   initial begin
      o_sck  = 1'b0;
      o_sdi  = 1'b0;
      o_ss_n = 1'b1;
   end
   task automatic frame(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
      #(1.3);
      rx = 8'hff;
      o_ss_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         o_sdi = tx[7-i];
         #(HALF_NS);
         o_sck = 1'b1;
         // an undriven line reads at its pull-up level
         rx = {rx[6:0], i_sdo_oe ? i_sdo : 1'b1};
         #(HALF_NS);
         o_sck = 1'b0;
      end
      #(HALF_NS);
      o_ss_n = 1'b1;
      // released line must not keep its last level
      o_sdi = ~o_sdi;
      // select must stay high long enough for the port to see it
      #(HALF_NS);
   endtask
endmodule
`default_nettype wire

//--- test/ssc_spi_port_assertions.sv
// pin and bus checker for the spi port
`timescale 1ns/10ps
`default_nettype none
module ssc_spi_port_assertions (
   // clock, reset, enable
   input wire logic       I_MCLK,
   input wire logic       I_SYS_RST,
   input wire logic       I_CE,
   // bus
   input wire logic [4:0] I_AVS_ADDRESS,
   input wire logic       I_AVS_READ,
   input wire logic       I_AVS_WRITE,
   input wire logic       O_AVS_WAITREQUEST,
   // power and pacing
   input wire logic       I_SLEEP,
   input wire logic       I_IDLE,
   input wire logic       I_PERIPH_TICK,
   input wire logic       I_TMR_TICK,
   input wire logic       I_SDO_DIR_IN,
   // pins and events
   input wire logic       I_SS_N,
   input wire logic       O_SCK,
   input wire logic       O_SCK_OE,
   input wire logic       O_SDO_OE,
   input wire logic       O_IRQ,
   input wire logic       O_WAKE
);
   default clocking cb @(posedge I_MCLK); endclocking
   default disable iff (I_SYS_RST);
   sequence bus_req;
      (I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST && I_CE;
   endsequence
   sequence stat_read;
      I_AVS_READ && I_AVS_ADDRESS == ssc_pkg::OFS_IRQ_STATUS && !O_AVS_WAITREQUEST;
   endsequence
   sequence ss_rise;
      $rose(I_SS_N) && !O_SCK_OE;
   endsequence
   sequence asleep;
      I_SLEEP [*3];
   endsequence
   bus_answer_a: assert property (bus_req |=> !O_AVS_WAITREQUEST)
      else $error("bus request not answered after one cycle");
   bus_wait_a: assert property ($rose(I_AVS_READ || I_AVS_WRITE) |-> O_AVS_WAITREQUEST)
      else $error("bus request taken without a wait cycle");
   sdo_input_a: assert property (I_SDO_DIR_IN ##1 I_SDO_DIR_IN |-> !O_SDO_OE)
      else $error("data output driven while set as input");
   ss_release_a: assert property (ss_rise |-> ##[1:4] !O_SDO_OE)
      else $error("data output still driven after select rose");
   sleep_freeze_a: assert property (asleep |-> $stable(O_SCK))
      else $error("serial clock moved during sleep");
   sck_paced_a: assert property ($changed(O_SCK) && O_SCK_OE && $past(O_SCK_OE) |->
      $past(I_PERIPH_TICK) || $past(I_TMR_TICK) || $past(I_PERIPH_TICK, 2))
      else $error("serial clock moved without a tick");
   wake_cause_a: assert property (O_WAKE |-> O_IRQ && ($past(I_SLEEP) || $past(I_IDLE)))
      else $error("wake without interrupt or power mode");
   irq_clear_a: assert property (stat_read |-> ##[1:3] !O_IRQ)
      else $error("interrupt stays up after status read");
   reset_quiet_a: assert property ($fell(I_SYS_RST) |->
      !O_SCK_OE && !O_SDO_OE && !O_IRQ && !O_WAKE)
      else $error("outputs active right after reset");
endmodule
bind ssc_spi_port ssc_spi_port_assertions i_ssc_spi_port_assertions (
   .I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_CE(I_CE), .I_AVS_ADDRESS(I_AVS_ADDRESS),
   .I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
   .I_SLEEP(I_SLEEP), .I_IDLE(I_IDLE), .I_PERIPH_TICK(I_PERIPH_TICK), .I_TMR_TICK(I_TMR_TICK),
   .I_SDO_DIR_IN(I_SDO_DIR_IN), .I_SS_N(I_SS_N), .O_SCK(O_SCK), .O_SCK_OE(O_SCK_OE),
   .O_SDO_OE(O_SDO_OE), .O_IRQ(O_IRQ), .O_WAKE(O_WAKE));
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the spi port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [4:0]  adr = 5'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wdat = 32'h0;
   logic        sleep = 1'b0;
   logic        idle = 1'b0;
   logic        tick = 1'b0;
   logic        dir_in = 1'b0;
   logic        loop = 1'b0;
   logic        ce = 1'b1;
   logic [31:0] rdat, seen;
   logic        wreq, m_sck, m_sdi, m_ss_n, sck, sck_oe, sdo, sdo_oe, irq, wake;
   int          num_errors = 0;
   int          n_compared = 0;
   int          n_rise = 0;
   ssc_spi_port i_ssc_spi_port (
      .I_MCLK(clk), .I_SYS_RST(rst), .I_CE(ce), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd),
      .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdat), .I_AVS_BYTEENABLE(4'hf),
      .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wreq), .I_SLEEP(sleep), .I_IDLE(idle),
      .I_PERIPH_TICK(tick), .I_TMR_TICK(tick), .I_SDO_DIR_IN(dir_in), .I_SCK(m_sck),
      .O_SCK(sck), .O_SCK_OE(sck_oe), .I_SDI(loop ? sdo : m_sdi), .O_SDO(sdo),
      .O_SDO_OE(sdo_oe), .I_SS_N(m_ss_n), .O_IRQ(irq), .O_WAKE(wake));
   ssc_spi_far_master i_ssc_spi_far_master (
      .i_sdo(sdo), .i_sdo_oe(sdo_oe), .o_sck(m_sck), .o_sdi(m_sdi), .o_ss_n(m_ss_n));
   always #2 clk = ~clk;
   always @(posedge clk) tick <= ~tick;
   always @(posedge sck) if (sck_oe) n_rise++;
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic close_out();
      if (num_errors == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      rd <= !w;
      wr <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      seen = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      if (n >= 50) begin
         num_errors++;
         close_out();
      end
   endtask
   task automatic rchk(input string what, input logic [4:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(what, exp, seen);
   endtask
   task automatic s_regs();
      rchk("control", ssc_pkg::OFS_CONTROL, 32'h0);
      rchk("status", ssc_pkg::OFS_STATUS, 32'h0);
      bus(1'b1, 5'h14, 32'hff);
      rchk("unmapped", 5'h14, 32'h0);
      for (int m = 0; m < 6; m++) begin
         bus(1'b1, ssc_pkg::OFS_CONTROL, 32'(m) | 32'h10);
         rchk("mode", ssc_pkg::OFS_CONTROL, 32'(m) | 32'h10);
      end
   endtask
   task automatic s_slave();
      logic [7:0] got;
      bus(1'b1, ssc_pkg::OFS_IRQ_MASK, 32'h1);
      bus(1'b1, ssc_pkg::OFS_STATUS, 32'h40);
      bus(1'b1, ssc_pkg::OFS_CONTROL, 32'h24);
      bus(1'b1, ssc_pkg::OFS_DATA_BUF, 32'h3c);
      sleep <= 1'b1;
      i_ssc_spi_far_master.frame(8'ha5, 8, got);
      chk("slave tx", 32'h3c, got);
      @(posedge clk);
      chk("irq", 32'h1, irq);
      chk("wake", 32'h1, wake);
      sleep <= 1'b0;
      rchk("status", ssc_pkg::OFS_STATUS, 32'h41);
      rchk("rx byte", ssc_pkg::OFS_DATA_BUF, 32'ha5);
      rchk("irq status", ssc_pkg::OFS_IRQ_STATUS, 32'h1);
      rchk("irq status", ssc_pkg::OFS_IRQ_STATUS, 32'h0);
   endtask
   task automatic s_abort();
      logic [7:0] got;
      // cut after four bits: the next byte must still align
      i_ssc_spi_far_master.frame(8'hf0, 4, got);
      @(posedge clk);
      dir_in <= 1'b1;
      i_ssc_spi_far_master.frame(8'h96, 8, got);
      chk("receive only", 32'hff, got);
      rchk("resync byte", ssc_pkg::OFS_DATA_BUF, 32'h96);
      rchk("irq status", ssc_pkg::OFS_IRQ_STATUS, 32'h1);
      dir_in <= 1'b0;
   endtask
   task automatic s_master();
      int r0;
      loop <= 1'b1;
      n_rise = 0;
      bus(1'b1, ssc_pkg::OFS_CONTROL, 32'h20);
      bus(1'b1, ssc_pkg::OFS_DATA_BUF, 32'h81);
      repeat (10) @(posedge clk);
      sleep <= 1'b1;
      // an edge launched at this same clock still counts
      @(posedge clk);
      r0 = n_rise;
      repeat (40) @(posedge clk);
      chk("frozen edges", r0, n_rise);
      sleep <= 1'b0;
      idle <= 1'b1;
      for (int n = 0; irq !== 1'b1; n++) begin
         @(posedge clk);
         if (n > 2000) begin
            num_errors++;
            close_out();
         end
      end
      @(posedge clk);
      chk("wake idle", 32'h1, wake);
      chk("sck edges", 32'h8, n_rise);
      rchk("loop byte", ssc_pkg::OFS_DATA_BUF, 32'h81);
      rchk("irq status", ssc_pkg::OFS_IRQ_STATUS, 32'h1);
      bus(1'b1, ssc_pkg::OFS_IRQ_MASK, 32'h0);
      bus(1'b1, ssc_pkg::OFS_DATA_BUF, 32'h7e);
      ce <= 1'b0;
      @(posedge clk);
      r0 = n_rise;
      repeat (20) @(posedge clk);
      chk("ce frozen", r0, n_rise);
      ce <= 1'b1;
      // longer than one byte at this tick rate
      repeat (100) @(posedge clk);
      chk("masked irq", 32'h0, irq);
      chk("masked wake", 32'h0, wake);
      rchk("irq status", ssc_pkg::OFS_IRQ_STATUS, 32'h1);
      idle <= 1'b0;
   endtask
   task automatic s_modes();
      rchk("held byte", ssc_pkg::OFS_DATA_BUF, 32'h7e);
      bus(1'b1, ssc_pkg::OFS_STATUS, 32'h00);
      bus(1'b1, ssc_pkg::OFS_CONTROL, 32'h31);
      repeat (2) @(posedge clk);
      chk("idle high", 32'h1, sck);
      n_rise = 0;
      bus(1'b1, ssc_pkg::OFS_DATA_BUF, 32'hc3);
      // sixteen clocks per half bit: three rises by now, eight at /4
      repeat (120) @(posedge clk);
      chk("div16 pace", 32'h3, n_rise);
      repeat (180) @(posedge clk);
      chk("div16 edges", 32'h8, n_rise);
      rchk("mode 1,1 byte", ssc_pkg::OFS_DATA_BUF, 32'hc3);
      // late sampling lets the looped bit settle at the fast timer rate
      bus(1'b1, ssc_pkg::OFS_STATUS, 32'hc0);
      bus(1'b1, ssc_pkg::OFS_CONTROL, 32'h23);
      repeat (2) @(posedge clk);
      n_rise = 0;
      bus(1'b1, ssc_pkg::OFS_DATA_BUF, 32'h5a);
      repeat (60) @(posedge clk);
      chk("timer edges", 32'h8, n_rise);
      rchk("late sample byte", ssc_pkg::OFS_DATA_BUF, 32'h5a);
   endtask
   task automatic s_reset();
      bus(1'b1, ssc_pkg::OFS_DATA_BUF, 32'h5a);
      repeat (8) @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      chk("sck oe", 32'h0, sck_oe);
      rst <= 1'b0;
      loop <= 1'b0;
      rchk("control", ssc_pkg::OFS_CONTROL, 32'h0);
      rchk("irq status", ssc_pkg::OFS_IRQ_STATUS, 32'h0);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      s_regs();
      s_slave();
      s_abort();
      s_master();
      s_modes();
      s_reset();
      close_out();
   end
endmodule
`default_nettype wire
